// File: core/ext_bus_map.svh
// constants for the external memory strobe bus: field positions, reset values, phase lengths
// assumes inclusion by bare name from the package and design files
`ifndef EXT_BUS_MAP_SVH
`define EXT_BUS_MAP_SVH
`define ADDR_W          16
`define LOW_W           8
`define UPPER_LSB       8
`define UPPER_MSB       15
`define STROBE_IDLE     1'b1
`define RW_IDLE         1'b1
`define ROMLESS_DEFAULT 1'b1
`define PHASE_CYC       2'h1
`endif

// File: core/ext_bus_pkg.sv
// types for the external memory strobe bus
// assumes ext_bus_map.svh is on the include path
`include "ext_bus_map.svh"
package ext_bus_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_LATCH, ST_TURN, ST_DATA, ST_DONE
    } cycle_state_t;
    typedef logic [`ADDR_W-1:0] bus_addr_t;
    typedef logic [`LOW_W-1:0]  bus_byte_t;
endpackage : ext_bus_pkg

// File: core/pin_drive_if.sv
// carrier between the sequencer and the pin stage: wanted pin values and enables
// assumes a single clock domain
`timescale 1ns/1ps
interface pin_drive_if;
    logic       as_n;     // wanted address strobe
    logic       ds_n;     // wanted data strobe
    logic       rw;       // wanted direction
    logic [7:0] low_out;  // wanted low port value
    logic       low_oe;   // low port drive
    logic [7:0] upper;    // upper address
    logic       ctl_en;   // strobe pins enabled
    logic       rw_en;    // direction pin enabled
    modport seq (output as_n, ds_n, rw, low_out, low_oe, upper, ctl_en, rw_en);
    modport pins (input as_n, ds_n, rw, low_out, low_oe, upper, ctl_en, rw_en);
endinterface : pin_drive_if

// File: core/pin_stage.sv
// registered pin stage: every pad signal leaves from a flip-flop
// assumes the sequencer drives the interface; float removes every enable at once
`timescale 1ns/1ps
`include "ext_bus_map.svh"
module pin_stage
    import ext_bus_pkg::*;
(
    input  wire logic   ref_clk,           // core clock
    input  wire logic   nrst,              // async reset, active low
    input  wire logic   float_bus,         // software float request
    pin_drive_if.pins   drv,               // wanted values
    output logic        as_o,              // address strobe level
    output logic        as_oe,             // address strobe enable
    output logic        ds_o,              // data strobe level
    output logic        ds_oe,             // data strobe enable
    output logic        rw_o,              // direction level
    output logic        rw_oe,             // direction enable
    output logic [7:0]  low_o,             // low port level
    output logic [7:0]  low_oe,            // low port enables
    output logic [7:0]  up_o,              // upper port level
    output logic [7:0]  up_oe              // upper port enables
);
    logic [7:0] low_oe_next;
    logic [7:0] up_oe_next;
    logic       as_oe_next, ds_oe_next, rw_oe_next;

    // float takes all pins together, a half-floated bus would confuse latches
    always_comb begin
        as_oe_next  = drv.ctl_en & ~float_bus;                  // [RULE8]
        ds_oe_next  = drv.ctl_en & ~float_bus;                  // [RULE8]
        rw_oe_next  = drv.rw_en & ~float_bus;                   // [RULE8]
        up_oe_next  = {8{drv.ctl_en & ~float_bus}};             // [RULE8]
        low_oe_next = {8{drv.low_oe & drv.ctl_en & ~float_bus}};   // [RULE8]
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            as_o   <= `STROBE_IDLE;
            ds_o   <= `STROBE_IDLE;
            rw_o   <= `RW_IDLE;
            low_o  <= 8'h00;
            up_o   <= 8'h00;
            as_oe  <= 1'b0;
            ds_oe  <= 1'b0;
            rw_oe  <= 1'b0;
            low_oe <= 8'h00;
            up_oe  <= 8'h00;
        end else begin
            as_o   <= drv.as_n;
            ds_o   <= drv.ds_n;
            rw_o   <= drv.rw;
            low_o  <= drv.low_out;
            up_o   <= drv.upper;
            as_oe  <= as_oe_next;
            ds_oe  <= ds_oe_next;
            rw_oe  <= rw_oe_next;
            low_oe <= low_oe_next;
            up_oe  <= up_oe_next;
        end
    end
endmodule : pin_stage

// File: core/read_capture.sv
// read data capture at the data strobe's trailing edge
// assumes the far side holds read data valid before the strobe rises
`timescale 1ns/1ps
module read_capture
    import ext_bus_pkg::*;
(
    input  wire logic      ref_clk,       // core clock
    input  wire logic      nrst,          // async reset, active low
    input  wire logic      sample,        // one-cycle strobe-rise pulse
    input  wire bus_byte_t low_i,         // low port input
    output bus_byte_t      data_reg,      // captured byte
    output logic           valid_reg      // one-cycle done pulse
);
    bus_byte_t data_next;
    logic      valid_next;

    // hold last byte until the next external read completes
    always_comb begin
        data_next  = sample ? low_i : data_reg;   // [RULE5]
        valid_next = sample;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            data_reg  <= 8'h00;
            valid_reg <= 1'b0;
        end else begin
            data_reg  <= data_next;
            valid_reg <= valid_next;
        end
    end
endmodule : read_capture

// File: core/ext_bus_ctrl.sv
// external memory strobe bus sequencer: frames each cycle with the strobes
// assumes the core holds its request fields until done is seen; one clock domain
`timescale 1ns/1ps
`include "ext_bus_map.svh"
// Summary of operation
// RULE1 - address strobe pulses low exactly once at the start of each cycle
// RULE2 - address, direction and data-memory flag stable before address strobe rises
// RULE3 - data strobe times every low-port data transfer of an external cycle
// RULE4 - in writes, write data already driven when data strobe falls
// RULE5 - in reads, memory presents data before data strobe rises; sampled there
// RULE6 - internal memory accesses keep data strobe high through the whole cycle
// RULE7 - direction line low for external writes, high for everything else
// RULE8 - software float puts strobes, direction and both ports in high impedance
// RULE9 - romless variant has both strobes active right after reset
// RULE10 - romless variant keeps direction pin off after reset until software enables it
// RULE11 - sixteen lines from low and upper ports form a 64 Kbyte address
// RULE12 - low port carries muxed address/data bits, upper port address bits 8 to 15
// RULE13 - low address held until after address strobe rises, then port turns to data
module ext_bus_ctrl
    import ext_bus_pkg::*;
(
    input  wire logic      ref_clk,         // core clock, 100 MHz
    input  wire logic      nrst,            // async reset, active low
    input  wire logic      romless,         // variant strap, high for no program memory
    input  wire logic      bus_enable,      // software enables strobes on rom parts
    input  wire logic      rw_enable,       // software enables direction pin
    input  wire logic      float_bus,       // software float request
    input  wire logic      req,             // core requests a memory cycle
    input  wire logic      req_write,       // cycle is a write
    input  wire logic      req_internal,    // cycle targets on-chip memory
    input  wire logic      req_data_mem,    // data-memory flag for the cycle
    input  wire bus_addr_t req_addr,        // cycle address
    input  wire bus_byte_t req_wdata,       // write data
    input  wire bus_byte_t low_i,           // low port input
    output logic           busy,            // cycle in progress
    output logic           done,            // one-cycle completion pulse
    output bus_byte_t      rdata,           // read byte
    output logic           data_mem,        // data-memory indication
    output logic           addr_strobe_n_o, // address strobe level
    output logic           addr_strobe_n_oe,// address strobe enable
    output logic           data_strobe_n_o, // data strobe level
    output logic           data_strobe_n_oe,// data strobe enable
    output logic           rw_o,            // direction level
    output logic           rw_oe,           // direction enable
    output bus_byte_t      low_muxed_port_o,   // low port level
    output bus_byte_t      low_muxed_port_oe,  // low port enables
    output bus_byte_t      upper_address_port_o,  // upper port level
    output bus_byte_t      upper_address_port_oe  // upper port enables
);
    pin_drive_if drv ();

    cycle_state_t state_reg, state_next;
    bus_addr_t    addr_reg, addr_next;
    bus_byte_t    wdata_reg, wdata_next;
    logic         write_reg, write_next;
    logic         intl_reg, intl_next;
    logic         dmem_reg, dmem_next;
    logic         strap_reg, strap_next;
    logic         strap_seen_reg, strap_seen_next;
    logic         busy_reg, busy_next;
    logic         sample;
    logic         rdone;

    // strap caught by a clock after reset release, never under the reset itself
    always_comb begin
        strap_seen_next = 1'b1;
        strap_next      = strap_seen_reg ? strap_reg : romless;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            strap_reg      <= `ROMLESS_DEFAULT;
            strap_seen_reg <= 1'b0;
        end else begin
            strap_reg      <= strap_next;
            strap_seen_reg <= strap_seen_next;
        end
    end

    // cycle sequencer: addr phase, strobe rise, turn, data phase, done
    always_comb begin
        state_next = state_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        write_next = write_reg;
        intl_next  = intl_reg;
        dmem_next  = dmem_reg;
        busy_next  = busy_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (req) begin
                    addr_next  = req_addr;          // [RULE2]
                    wdata_next = req_wdata;
                    write_next = req_write;
                    intl_next  = req_internal;
                    dmem_next  = req_data_mem;
                    busy_next  = 1'b1;
                    state_next = ST_ADDR;
                end
            end
            ST_ADDR:  state_next = ST_LATCH;
            ST_LATCH: state_next = ST_TURN;
            ST_TURN:  state_next = ST_DATA;
            ST_DATA:  state_next = ST_DONE;
            ST_DONE: begin
                busy_next  = 1'b0;
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            addr_reg  <= 16'h0000;
            wdata_reg <= 8'h00;
            write_reg <= 1'b0;
            intl_reg  <= 1'b0;
            dmem_reg  <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            write_reg <= write_next;
            intl_reg  <= intl_next;
            dmem_reg  <= dmem_next;
            busy_reg  <= busy_next;
        end
    end

    // wanted pin values; pin_stage adds one register so pads lag state by one
    always_comb begin
        drv.as_n    = (state_reg == ST_ADDR) ? 1'b0 : `STROBE_IDLE;      // [RULE1]
        drv.ds_n    = ((state_reg == ST_DATA) && !intl_reg) ? 1'b0
                      : `STROBE_IDLE;                                    // [RULE3] [RULE6]
        drv.rw      = (busy_reg && write_reg && !intl_reg) ? 1'b0
                      : `RW_IDLE;                                        // [RULE7]
        drv.upper   = addr_reg[`UPPER_MSB:`UPPER_LSB];                   // [RULE11] [RULE12]
        // address stays through the strobe rise; write data is up a phase ahead of ds
        drv.low_out = (state_reg == ST_ADDR || state_reg == ST_LATCH)
                      ? addr_reg[`LOW_W-1:0] : wdata_reg;                // [RULE13] [RULE4]
        drv.low_oe  = (state_reg == ST_ADDR || state_reg == ST_LATCH)
                      || (busy_reg && write_reg && !intl_reg);           // [RULE13] [RULE4]
        drv.ctl_en  = strap_reg | bus_enable;                            // [RULE9]
        drv.rw_en   = rw_enable;                                         // [RULE10]
    end

    // pad ds rises one cycle after ST_DATA ends; sample then
    assign sample = (state_reg == ST_DONE) && !write_reg && !intl_reg;   // [RULE5]

    pin_stage u_pins (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .float_bus (float_bus),
        .drv       (drv),
        .as_o      (addr_strobe_n_o),
        .as_oe     (addr_strobe_n_oe),
        .ds_o      (data_strobe_n_o),
        .ds_oe     (data_strobe_n_oe),
        .rw_o      (rw_o),
        .rw_oe     (rw_oe),
        .low_o     (low_muxed_port_o),
        .low_oe    (low_muxed_port_oe),
        .up_o      (upper_address_port_o),
        .up_oe     (upper_address_port_oe)
    );

    read_capture u_cap (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .sample    (sample),
        .low_i     (low_i),
        .data_reg  (rdata),
        .valid_reg (rdone)
    );

    // status outputs straight from flip-flops
    logic data_mem_next;
    always_comb data_mem_next = dmem_reg;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            data_mem <= 1'b0;
            done     <= 1'b0;
        end else begin
            data_mem <= data_mem_next;
            done     <= (state_reg == ST_DONE);
        end
    end
    assign busy = busy_reg;

    // helper: address strobe low pulses seen in the current cycle
    logic [1:0] as_cnt;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            as_cnt <= 2'h0;
        end else if (state_reg == ST_IDLE) begin
            as_cnt <= 2'h0;
        end else if (!drv.as_n) begin
            as_cnt <= as_cnt + 2'h1;
        end
    end

    sequence s_start;
        (state_reg == ST_IDLE) && req;
    endsequence
    sequence s_as_pulse;
        !addr_strobe_n_o ##1 addr_strobe_n_o;
    endsequence

    property p_as_once;
        @(posedge ref_clk) disable iff (!nrst)
        s_start |-> ##2 s_as_pulse;
    endproperty
    a_as_once: assert property (p_as_once) else $error("as not pulsed once"); // [RULE1]

    property p_as_count;
        @(posedge ref_clk) disable iff (!nrst)
        as_cnt <= 2'h1;
    endproperty
    a_as_count: assert property (p_as_count) else $error("as pulsed twice"); // [RULE1]

    property p_addr_stable;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(addr_strobe_n_o) |-> $stable(upper_address_port_o) && $stable(rw_o)
                                   && $stable(low_muxed_port_o);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("addr moved at as rise"); // [RULE2]

    property p_ds_internal;
        @(posedge ref_clk) disable iff (!nrst)
        s_start ##0 req_internal |-> ##1 data_strobe_n_o [*5];
    endproperty
    a_ds_internal: assert property (p_ds_internal) else $error("ds low on internal"); // [RULE6]

    property p_ds_external;
        @(posedge ref_clk) disable iff (!nrst)
        s_start ##0 !req_internal |-> ##5 !data_strobe_n_o ##1 data_strobe_n_o;
    endproperty
    a_ds_external: assert property (p_ds_external) else $error("ds missing"); // [RULE3]

    property p_wdata_at_ds;
        @(posedge ref_clk) disable iff (!nrst)
        $fell(data_strobe_n_o) && !rw_o |->
            low_muxed_port_oe == 8'hff && low_muxed_port_o == $past(wdata_reg);
    endproperty
    a_wdata_at_ds: assert property (p_wdata_at_ds) else $error("write data late"); // [RULE4]

    property p_rw_dir;
        @(posedge ref_clk) disable iff (!nrst)
        s_start ##0 req_write && !req_internal |-> ##2 !rw_o [*5] ##1 rw_o;
    endproperty
    a_rw_dir: assert property (p_rw_dir) else $error("direction wrong"); // [RULE7]

    property p_float;
        @(posedge ref_clk) disable iff (!nrst)
        float_bus |-> ##1 !addr_strobe_n_oe && !data_strobe_n_oe && !rw_oe
                         && low_muxed_port_oe == 8'h00 && upper_address_port_oe == 8'h00;
    endproperty
    a_float: assert property (p_float) else $error("bus not floated"); // [RULE8]

    property p_rw_off;
        @(posedge ref_clk) disable iff (!nrst)
        !rw_enable |-> ##1 !rw_oe;
    endproperty
    a_rw_off: assert property (p_rw_off) else $error("rw driven while off"); // [RULE10]

    property p_turn;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(addr_strobe_n_o) |-> low_muxed_port_o == $past(addr_reg[7:0]);
    endproperty
    a_turn: assert property (p_turn) else $error("low addr dropped early"); // [RULE13]

    property p_rw_read;
        @(posedge ref_clk) disable iff (!nrst)
        s_start ##0 !req_write |-> ##1 rw_o [*6];
    endproperty
    a_rw_read: assert property (p_rw_read) else $error("direction low on read"); // [RULE7]

    property p_upper_addr;
        @(posedge ref_clk) disable iff (!nrst)
        (state_reg == ST_LATCH) |-> upper_address_port_o == addr_reg[`UPPER_MSB:`UPPER_LSB];
    endproperty
    a_upper_addr: assert property (p_upper_addr) else $error("upper address wrong"); // [RULE12]

    property p_rd_capture;
        @(posedge ref_clk) disable iff (!nrst)
        sample |=> rdata == $past(low_i);
    endproperty
    a_rd_capture: assert property (p_rd_capture) else $error("read byte not captured"); // [RULE5]

    property p_wr_lead;
        @(posedge ref_clk) disable iff (!nrst)
        $fell(data_strobe_n_o) && !rw_o |->
            $past(low_muxed_port_oe) == {8{$past(data_strobe_n_oe)}};
    endproperty
    a_wr_lead: assert property (p_wr_lead) else $error("write data not ahead of ds"); // [RULE4]

    property p_romless_on;
        @(posedge ref_clk) disable iff (!nrst)
        strap_reg && !float_bus |=> addr_strobe_n_oe && data_strobe_n_oe;
    endproperty
    a_romless_on: assert property (p_romless_on) else $error("strobes off on romless"); // [RULE9]
endmodule : ext_bus_ctrl

// File: dv/ext_mem_model.sv
// behavioural external memory hanging on the multiplexed strobe bus
// assumes the bench resolves pads; released ports read high through weak pull-ups
`timescale 1ns/1ps
module ext_mem_model
    import ext_bus_pkg::*;
(
    input  wire logic      as_n,     // address strobe pad
    input  wire logic      ds_n,     // data strobe pad
    input  wire logic      rw,       // direction pad
    input  wire bus_byte_t up_pad,   // upper address pad
    input  wire bus_byte_t low_pad,  // low port pad
    input  wire logic      slow,     // present read data late
    output logic           drv_en,   // model drives the low port
    output bus_byte_t      drv_data  // model low port value
);
    bus_addr_t addr_reg;
    bus_byte_t mem [bus_addr_t];
    bus_byte_t val;

    initial begin
        drv_en = 1'b0;
        drv_data = 8'h00;
    end

    // address is taken on the strobe's rising edge; direction is read at the data strobe edges
    always @(posedge as_n) begin
        addr_reg = {up_pad, low_pad};
    end

    // read data only while the data strobe is low; slow mode shows junk first
    always @(negedge ds_n) begin
        if (rw === 1'b1) begin
            val = mem.exists(addr_reg) ? mem[addr_reg] : (addr_reg[7:0] ^ addr_reg[15:8] ^ 8'h5a);
            drv_data = slow ? ~val : val;
            drv_en = 1'b1;
            if (slow) begin
                #7 drv_data = val; // still ahead of the trailing edge
            end
        end
    end

    // trailing edge: release the port, store write data
    always @(posedge ds_n) begin
        drv_en = 1'b0;
        if (rw === 1'b0) begin
            mem[addr_reg] = low_pad;
        end
    end
endmodule : ext_mem_model

// File: dv/test_ext_bus_ctrl.sv
// self-checking bench for the external memory strobe bus sequencer
// assumes ext_mem_model on the far side; strobe pads pulled high when released
`timescale 1ns/1ps
module test_ext_bus_ctrl
    import ext_bus_pkg::*;
;
    logic      ref_clk, nrst, romless, bus_enable, rw_enable, float_bus, slow;
    logic      req, req_write, req_internal, req_data_mem;
    bus_addr_t req_addr;
    bus_byte_t req_wdata, low_pad, up_pad, mem_data, last_rd;
    logic      busy, done, data_mem, as_o, as_oe, ds_o, ds_oe, rw_o, rw_oe, mem_en;
    bus_byte_t rdata, low_o, low_oe, up_o, up_oe;
    bus_byte_t seen_wr [bus_addr_t];
    int        bad_count, n_compared, cyc;

    ext_bus_ctrl uut (.ref_clk(ref_clk), .nrst(nrst), .romless(romless),
        .bus_enable(bus_enable), .rw_enable(rw_enable), .float_bus(float_bus), .req(req),
        .req_write(req_write), .req_internal(req_internal), .req_data_mem(req_data_mem),
        .req_addr(req_addr), .req_wdata(req_wdata), .low_i(low_pad), .busy(busy), .done(done),
        .rdata(rdata), .data_mem(data_mem), .addr_strobe_n_o(as_o), .addr_strobe_n_oe(as_oe),
        .data_strobe_n_o(ds_o), .data_strobe_n_oe(ds_oe), .rw_o(rw_o), .rw_oe(rw_oe),
        .low_muxed_port_o(low_o), .low_muxed_port_oe(low_oe),
        .upper_address_port_o(up_o), .upper_address_port_oe(up_oe));

    ext_mem_model mem (.as_n(as_oe ? as_o : 1'b1), .ds_n(ds_oe ? ds_o : 1'b1),
        .rw(rw_oe ? rw_o : 1'b1), .up_pad(up_pad), .low_pad(low_pad), .slow(slow),
        .drv_en(mem_en), .drv_data(mem_data));

    // pad resolution; both ports carry weak pull-ups
    assign low_pad = (low_oe & low_o) | (~low_oe & (mem_en ? mem_data : 8'hff));
    assign up_pad  = (up_oe & up_o) | ~up_oe;

    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    // hang guard, far above the hundred or so cycles the tests take
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    // eight cycles of reset, pins quiet throughout, then three to settle
    task automatic do_reset(input logic strap);
        @(negedge ref_clk);
        nrst = 1'b0;
        romless = strap;
        repeat (8) @(negedge ref_clk);
        check("rst_levels", {as_o, ds_o, rw_o, low_oe, up_oe}, 19'h70000);
        nrst = 1'b1;
        repeat (3) @(negedge ref_clk);
    endtask : do_reset

    // one memory cycle, watching the pins at every falling edge
    task automatic run_cycle(input logic w, input logic im, input logic dm, input bus_addr_t a,
                             input bus_byte_t wd, input bus_byte_t exp_rd);
        int  n, as_falls, ds_low;
        logic as_prev, ds_prev;
        n = 0;
        as_falls = 0;
        ds_low = 0;
        as_prev = as_o;
        ds_prev = ds_o;
        {req, req_write, req_internal, req_data_mem, req_addr, req_wdata} = {1'b1, w, im, dm, a, wd};
        @(negedge ref_clk);
        req = 1'b0;
        while (done !== 1'b1 && n < 12) begin
            @(negedge ref_clk);
            n++;
            check("busy", busy, done !== 1'b1);
            if (n == 3) check("turn_oe", low_oe, (w && !im && !float_bus) ? 8'hff : 8'h00);
            if (as_prev === 1'b1 && as_o === 1'b0) as_falls++;
            if (as_prev === 1'b0 && as_o === 1'b1) begin
                check("addr", {up_o, low_o}, a);
                check("addr_oe", low_oe, float_bus ? 8'h00 : 8'hff);
                check("rw", rw_o, !(w && !im));
                check("data_mem", data_mem, dm);
            end
            if (ds_prev === 1'b1 && ds_o === 1'b0) begin
                check("ds_fall_port", w ? low_o : low_oe, w ? wd : 8'h00);
            end
            if (ds_o !== 1'b1) ds_low++;
            as_prev = as_o;
            ds_prev = ds_o;
        end
        check("done_at", n, 5);
        check("as_pulses", as_falls, 1);
        check("ds_low_cycles", ds_low, im ? 0 : 1);
        check("rdata", rdata, exp_rd);
        last_rd = rdata;
    endtask : run_cycle

    function automatic bus_byte_t exp_read(input bus_addr_t a);
        return seen_wr.exists(a) ? seen_wr[a] : (a[7:0] ^ a[15:8] ^ 8'h5a);
    endfunction : exp_read

    task automatic test_romless_reset();
        do_reset(1'b1);
        check("strobe_oe", {as_oe, ds_oe, low_oe, up_oe}, 18'h300ff);
        check("rw_oe_off", rw_oe, 1'b0);
        rw_enable = 1'b1;
        repeat (2) @(negedge ref_clk);
        check("rw_oe_on", rw_oe, 1'b1);
        $display("test romless reset done");
    endtask : test_romless_reset

    // writes then reads back to back, boundary addresses, prompt and late data
    task automatic test_external();
        bus_addr_t adr [4] = '{16'h12a5, 16'hff00, 16'h0000, 16'hffff};
        bus_byte_t dat [4] = '{8'h3c, 8'hc3, 8'h81, 8'h7e};
        for (int i = 0; i < 4; i++) begin
            run_cycle(1'b1, 1'b0, i[0], adr[i], dat[i], last_rd);
            seen_wr[adr[i]] = dat[i];
        end
        for (int i = 0; i < 5; i++) begin
            slow = i[0];
            run_cycle(1'b0, 1'b0, !i[0], i < 4 ? adr[i] : 16'h0001, 8'h00,
                      exp_read(i < 4 ? adr[i] : 16'h0001));
        end
        slow = 1'b0;
        $display("test external done");
    endtask : test_external

    task automatic test_internal();
        run_cycle(1'b1, 1'b1, 1'b1, 16'h4000, 8'h99, last_rd);
        run_cycle(1'b0, 1'b1, 1'b0, 16'h12a5, 8'h00, last_rd);
        $display("test internal done");
    endtask : test_internal

    // float releases every pin; the cycle runs but reads only pull-ups
    task automatic test_float();
        float_bus = 1'b1;
        repeat (2) @(negedge ref_clk);
        check("float_oe", {as_oe, ds_oe, rw_oe, low_oe, up_oe}, 19'h0);
        run_cycle(1'b0, 1'b0, 1'b0, 16'h12a5, 8'h00, 8'hff);
        float_bus = 1'b0;
        repeat (2) @(negedge ref_clk);
        check("unfloat_oe", {as_oe, ds_oe, rw_oe}, 3'h7);
        $display("test float done");
    endtask : test_float

    // a part with program memory enables the strobes for one cycle after reset, then keeps them off until enabled
    task automatic test_rom_part();
        do_reset(1'b0);
        check("rom_strobe_oe", {as_oe, ds_oe}, 2'h0);
        bus_enable = 1'b1;
        repeat (2) @(negedge ref_clk);
        check("rom_en_oe", {as_oe, ds_oe, low_oe, up_oe}, 18'h300ff);
        run_cycle(1'b0, 1'b0, 1'b1, 16'hff00, 8'h00, 8'hc3);
        $display("test rom part done");
    endtask : test_rom_part

    initial begin
        {nrst, romless, bus_enable, rw_enable, float_bus, slow} = 6'h01;
        {req, req_write, req_internal, req_data_mem, req_addr, req_wdata} = '0;
        {bad_count, n_compared, cyc} = '0;
        last_rd = 8'h00;
        test_romless_reset();
        test_external();
        test_internal();
        test_float();
        test_rom_part();
        end_sim();
    end
endmodule : test_ext_bus_ctrl
